// ### include/dpram_pkg.sv
package dpram_pkg;
  localparam int ADDR_W_DEFAULT = 15;
  localparam int ADDR_W_MAX     = 19;
  localparam int LANES          = 4;
  localparam int LANE_W         = 9;
  localparam int DATA_W         = 36;
  localparam logic [1:0] MBOX_LEFT_OFS  = 2'h1;
  localparam logic [1:0] MBOX_RIGHT_OFS = 2'h2;
  localparam logic       FLAG_RESET     = 1'h1;
  localparam logic [3:0] LANES_NONE     = 4'h0;
  localparam int READ_LATENCY   = 2;
endpackage

// ### include/dpram_port_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dpram_port_if #(
  parameter int ADDR_W = 15
) (
  input wire logic ref_clk
);
  logic [ADDR_W-1:0] addr;
  logic [3:0]        byte_lane_enable_n;
  logic              rd_wr;
  logic              chip_select_low;
  logic              chip_select_high;
  logic              out_enable_n;
  logic [35:0]       dq_from_host;
  logic              dq_host_oe_n;
  logic [35:0]       dq_from_dev;
  logic              dq_dev_oe_n;
  logic              mailbox_flag_n;
  wire  [35:0]       dq_bus;

  assign dq_bus = !dq_dev_oe_n ? dq_from_dev : dq_from_host;

  modport device (
    input  addr, byte_lane_enable_n, rd_wr, chip_select_low, chip_select_high, out_enable_n,
    input  dq_from_host, dq_host_oe_n,
    output dq_from_dev, dq_dev_oe_n, mailbox_flag_n
  );
  modport host (
    output addr, byte_lane_enable_n, rd_wr, chip_select_low, chip_select_high, out_enable_n,
    output dq_from_host, dq_host_oe_n,
    input  dq_from_dev, dq_dev_oe_n, mailbox_flag_n
  );
endinterface
`default_nettype wire

// ### core/dpram_device.sv
// Contract
// RL1: four byte lanes, each separately enabled
// RL2: read/write select low writes, high reads
// RL3: output enable low drives data asynchronously
// RL4: select needs low select low, high high
// RL5: top two words are mailboxes
// RL6: write opposite mailbox drops its flag low
// RL7: reading own mailbox returns flag high
// RL8: address width 15 to 19 bits
// RL9: master reset asynchronous, resets both ports
// RL10: each port samples on own clock
`timescale 1ns/1ps
`default_nettype none
module dpram_device #(
  parameter int ADDR_W = dpram_pkg::ADDR_W_DEFAULT
) (
  input  wire logic   left_clk,
  input  wire logic   right_clk,
  input  wire logic   master_reset_in,
  dpram_port_if.device left,
  dpram_port_if.device right
);
  // RL8 depth follows address width
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [ADDR_W-1:0] MBOX_L = ADDR_W'(DEPTH - int'(dpram_pkg::MBOX_LEFT_OFS));
  localparam logic [ADDR_W-1:0] MBOX_R = ADDR_W'(DEPTH - int'(dpram_pkg::MBOX_RIGHT_OFS));

  // true dual port array; same-word same-edge writes are undefined
  logic [dpram_pkg::DATA_W-1:0] mem [DEPTH];

  // RL4 RL2 decode per port
  logic l_sel, r_sel, l_wr, r_wr, l_rd, r_rd;
  assign l_sel = !left.chip_select_low && left.chip_select_high;
  assign r_sel = !right.chip_select_low && right.chip_select_high;
  assign l_wr  = l_sel && !left.rd_wr;
  assign r_wr  = r_sel && !right.rd_wr;
  assign l_rd  = l_sel && left.rd_wr;
  assign r_rd  = r_sel && right.rd_wr;

  logic [dpram_pkg::DATA_W-1:0] l_q, r_q, next_l_q, next_r_q;
  logic [dpram_pkg::DATA_W-1:0] l_rdata, r_rdata;
  logic [3:0]                   l_lanes, r_lanes;
  logic                         l_rd_v, r_rd_v, next_l_rd_v, next_r_rd_v;

  // RL10 left-side array port on left clock
  // plain always: both port processes write the one array
  always @(posedge left_clk) begin
    for (int i = 0; i < dpram_pkg::LANES; i++) begin
      // RL1 masked lane write
      if (l_wr && !left.byte_lane_enable_n[i]) begin
        mem[left.addr][i*dpram_pkg::LANE_W +: dpram_pkg::LANE_W] <=
          left.dq_from_host[i*dpram_pkg::LANE_W +: dpram_pkg::LANE_W];
      end
    end
    l_rdata <= mem[left.addr];
    l_lanes <= left.byte_lane_enable_n;
  end

  // RL10 right-side array port on right clock
  always @(posedge right_clk) begin
    for (int i = 0; i < dpram_pkg::LANES; i++) begin
      // RL1 masked lane write
      if (r_wr && !right.byte_lane_enable_n[i]) begin
        mem[right.addr][i*dpram_pkg::LANE_W +: dpram_pkg::LANE_W] <=
          right.dq_from_host[i*dpram_pkg::LANE_W +: dpram_pkg::LANE_W];
      end
    end
    r_rdata <= mem[right.addr];
    r_lanes <= right.byte_lane_enable_n;
  end

  // pipelined output stage, disabled lanes read as zero
  always_comb begin
    next_l_q    = l_q;
    next_r_q    = r_q;
    if (l_rd_v) begin
      for (int i = 0; i < dpram_pkg::LANES; i++) begin
        // RL1 masked lane read
        next_l_q[i*dpram_pkg::LANE_W +: dpram_pkg::LANE_W] = l_lanes[i] ? '0 :
          l_rdata[i*dpram_pkg::LANE_W +: dpram_pkg::LANE_W];
      end
    end
    if (r_rd_v) begin
      for (int i = 0; i < dpram_pkg::LANES; i++) begin
        next_r_q[i*dpram_pkg::LANE_W +: dpram_pkg::LANE_W] = r_lanes[i] ? '0 :
          r_rdata[i*dpram_pkg::LANE_W +: dpram_pkg::LANE_W];
      end
    end
    next_l_rd_v = l_rd;
    next_r_rd_v = r_rd;
  end

  logic l_out_v, r_out_v, next_l_out_v, next_r_out_v;
  assign next_l_out_v = l_rd_v;
  assign next_r_out_v = r_rd_v;

  // RL9 async master reset on both sides
  always_ff @(posedge left_clk or posedge master_reset_in) begin
    if (master_reset_in) begin
      l_q     <= '0;
      l_rd_v  <= 1'b0;
      l_out_v <= 1'b0;
    end else begin
      l_q     <= next_l_q;
      l_rd_v  <= next_l_rd_v;
      l_out_v <= next_l_out_v;
    end
  end

  always_ff @(posedge right_clk or posedge master_reset_in) begin
    if (master_reset_in) begin
      r_q     <= '0;
      r_rd_v  <= 1'b0;
      r_out_v <= 1'b0;
    end else begin
      r_q     <= next_r_q;
      r_rd_v  <= next_r_rd_v;
      r_out_v <= next_r_out_v;
    end
  end

  // RL3 output enable gates drive without clock
  assign left.dq_from_dev  = l_q;
  assign right.dq_from_dev = r_q;
  assign left.dq_dev_oe_n  = !(l_out_v && !left.out_enable_n);
  assign right.dq_dev_oe_n = !(r_out_v && !right.out_enable_n);

  // RL5 mailbox words at top two addresses
  logic l_flag, r_flag, next_l_flag, next_r_flag;
  logic l_set_toggle, r_set_toggle, next_l_set_toggle, next_r_set_toggle;
  logic l_seen, r_seen, next_l_seen, next_r_seen;
  logic [1:0] l_sync, r_sync;

  // RL6 other side write toggles an event across clocks
  always_comb begin
    next_r_set_toggle = r_set_toggle ^ (l_wr && left.addr == MBOX_R);
    next_l_set_toggle = l_set_toggle ^ (r_wr && right.addr == MBOX_L);
  end

  always_ff @(posedge left_clk or posedge master_reset_in) begin
    if (master_reset_in) begin
      r_set_toggle <= 1'b0;
      l_sync       <= 2'h0;
      l_seen       <= 1'b0;
      l_flag       <= dpram_pkg::FLAG_RESET;
    end else begin
      r_set_toggle <= next_r_set_toggle;
      l_sync       <= {l_sync[0], l_set_toggle};
      l_seen       <= next_l_seen;
      l_flag       <= next_l_flag;
    end
  end

  always_ff @(posedge right_clk or posedge master_reset_in) begin
    if (master_reset_in) begin
      l_set_toggle <= 1'b0;
      r_sync       <= 2'h0;
      r_seen       <= 1'b0;
      r_flag       <= dpram_pkg::FLAG_RESET;
    end else begin
      l_set_toggle <= next_l_set_toggle;
      r_sync       <= {r_sync[0], r_set_toggle};
      r_seen       <= next_r_seen;
      r_flag       <= next_r_flag;
    end
  end

  // set wins over a clear in the same cycle
  always_comb begin
    next_l_seen = l_sync[1];
    next_r_seen = r_sync[1];
    next_l_flag = l_flag;
    next_r_flag = r_flag;
    // RL7 own mailbox read clears
    if (l_rd && left.addr == MBOX_L) begin
      next_l_flag = 1'b1;
    end
    if (r_rd && right.addr == MBOX_R) begin
      next_r_flag = 1'b1;
    end
    // RL6 flag goes low
    if (l_sync[1] != l_seen) begin
      next_l_flag = 1'b0;
    end
    if (r_sync[1] != r_seen) begin
      next_r_flag = 1'b0;
    end
  end

  assign left.mailbox_flag_n  = l_flag;
  assign right.mailbox_flag_n = r_flag;
endmodule
`default_nettype wire

// ### core/dpram_host.sv
`timescale 1ns/1ps
`default_nettype none
module dpram_host #(
  parameter int ADDR_W = dpram_pkg::ADDR_W_DEFAULT
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [3:0]        req_lanes,
  input  wire logic [35:0]       req_wdata,
  output logic                   rsp_valid,
  output logic [35:0]            rsp_rdata,
  output logic                   mailbox_pending,
  dpram_port_if.host             port
);
  typedef enum logic [1:0] {
    IDLE  = 2'h0,
    WAIT1 = 2'h1,
    WAIT2 = 2'h2,
    TAKE  = 2'h3
  } state_t;

  state_t             state, next_state;
  logic [ADDR_W-1:0]  addr, next_addr;
  logic [3:0]         lanes_n, next_lanes_n;
  logic               rd_wr, next_rd_wr, sel, next_sel;
  logic [35:0]        wdata, next_wdata, rdata, next_rdata;
  logic               rvalid, next_rvalid, oe_n, next_oe_n;
  logic [1:0]         flag_sync;

  assign req_ready = (state == IDLE);

  always_comb begin
    next_state   = state;
    next_addr    = addr;
    next_lanes_n = lanes_n;
    next_rd_wr   = rd_wr;
    next_sel     = 1'b0;
    next_wdata   = wdata;
    next_rdata   = rdata;
    next_rvalid  = 1'b0;
    next_oe_n    = oe_n;
    case (state)
      IDLE: begin
        if (req_valid) begin
          next_addr    = req_addr;
          // RL1 lane enables active low at pins
          next_lanes_n = ~req_lanes;
          // RL2 low means write
          next_rd_wr   = !req_write;
          next_wdata   = req_wdata;
          next_sel     = 1'b1;
          next_oe_n    = req_write;
          next_state   = req_write ? IDLE : WAIT1;
        end
      end
      WAIT1: begin
        next_state = WAIT2;
      end
      WAIT2: begin
        next_state = TAKE;
      end
      TAKE: begin
        next_rdata  = port.dq_from_dev;
        next_rvalid = 1'b1;
        next_oe_n   = 1'b1;
        next_state  = IDLE;
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state     <= IDLE;
      addr      <= '0;
      lanes_n   <= 4'hF;
      rd_wr     <= 1'b1;
      sel       <= 1'b0;
      wdata     <= '0;
      rdata     <= '0;
      rvalid    <= 1'b0;
      oe_n      <= 1'b1;
      flag_sync <= 2'h3;
    end else begin
      state     <= next_state;
      addr      <= next_addr;
      lanes_n   <= next_lanes_n;
      rd_wr     <= next_rd_wr;
      sel       <= next_sel;
      wdata     <= next_wdata;
      rdata     <= next_rdata;
      rvalid    <= next_rvalid;
      oe_n      <= next_oe_n;
      flag_sync <= {flag_sync[0], port.mailbox_flag_n};
    end
  end

  assign port.addr               = addr;
  assign port.byte_lane_enable_n = lanes_n;
  assign port.rd_wr              = rd_wr;
  // RL4 each select with own polarity
  assign port.chip_select_low    = !sel;
  assign port.chip_select_high   = sel;
  // RL3 output enable held low for reads
  assign port.out_enable_n       = oe_n;
  assign port.dq_from_host       = wdata;
  assign port.dq_host_oe_n       = !(sel && !rd_wr);
  assign rsp_valid               = rvalid;
  assign rsp_rdata               = rdata;
  assign mailbox_pending         = !flag_sync[1];
endmodule
`default_nettype wire

// ### testbench/dpram_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dpram_properties #(
  parameter int ADDR_W = 15
) (
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [3:0]        byte_lane_enable_n,
  input wire logic              rd_wr,
  input wire logic              chip_select_low,
  input wire logic              chip_select_high,
  input wire logic              out_enable_n,
  input wire logic              dq_host_oe_n,
  input wire logic [35:0]       dq_from_dev,
  input wire logic              dq_dev_oe_n,
  input wire logic              mailbox_flag_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic sel;
  assign sel = !chip_select_low && chip_select_high;
  property p_oe_release; out_enable_n |-> dq_dev_oe_n; endproperty
  a_oe_release: assert property (p_oe_release) else $error("data driven with output enable high");
  property p_sel_pair; !chip_select_low |-> chip_select_high; endproperty
  a_sel_pair: assert property (p_sel_pair) else $error("select halves disagree");
  property p_write_drive; sel && !rd_wr |-> !dq_host_oe_n && out_enable_n; endproperty
  a_write_drive: assert property (p_write_drive) else $error("write without host data");
  property p_no_fight; !(!dq_host_oe_n && !dq_dev_oe_n); endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
  property p_read_answer; sel && rd_wr |-> ##2 (out_enable_n || !dq_dev_oe_n); endproperty
  a_read_answer: assert property (p_read_answer) else $error("read data not driven");
  property p_lane_zero; sel && rd_wr && byte_lane_enable_n[0] |-> ##2 dq_from_dev[8:0] == 9'h000; endproperty
  a_lane_zero: assert property (p_lane_zero) else $error("disabled lane not zero");
  property p_read_gap; sel && rd_wr |=> !sel [*3]; endproperty
  a_read_gap: assert property (p_read_gap) else $error("reads too close");
  property p_mbox_clear; sel && rd_wr && (&addr) |-> ##[1:3] mailbox_flag_n; endproperty
  a_mbox_clear: assert property (p_mbox_clear) else $error("own mailbox read left flag low");
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int AW = 15;
  typedef struct {int s; logic w; logic [14:0] a; logic [3:0] ln; logic [35:0] d;} row_t;
  logic          ref_clk = 1'b0;
  logic          rst = 1'b1;
  logic [1:0]    req_valid, req_ready, req_write, rsp_valid, pending, flag_n;
  logic [AW-1:0] req_addr [2];
  logic [3:0]    req_lanes [2];
  logic [35:0]   req_wdata [2];
  logic [35:0]   rsp_rdata [2];
  logic [35:0]   q;
  int            mismatches = 0;
  int            checks_done = 0;
  row_t          rows [8];
  always #5 ref_clk = ~ref_clk;
  dpram_port_if #(.ADDR_W(AW)) lp (.ref_clk(ref_clk));
  dpram_port_if #(.ADDR_W(AW)) rp (.ref_clk(ref_clk));
  assign flag_n = {rp.mailbox_flag_n, lp.mailbox_flag_n};
  dpram_device #(.ADDR_W(AW)) u_dpram_device (.left_clk(ref_clk), .right_clk(ref_clk), .master_reset_in(rst),
    .left(lp), .right(rp));
  dpram_host #(.ADDR_W(AW)) u_dpram_host (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid[0]),
    .req_ready(req_ready[0]), .req_write(req_write[0]), .req_addr(req_addr[0]), .req_lanes(req_lanes[0]),
    .req_wdata(req_wdata[0]), .rsp_valid(rsp_valid[0]), .rsp_rdata(rsp_rdata[0]), .mailbox_pending(pending[0]),
    .port(lp));
  dpram_host #(.ADDR_W(AW)) u_dpram_host_r (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid[1]),
    .req_ready(req_ready[1]), .req_write(req_write[1]), .req_addr(req_addr[1]), .req_lanes(req_lanes[1]),
    .req_wdata(req_wdata[1]), .rsp_valid(rsp_valid[1]), .rsp_rdata(rsp_rdata[1]), .mailbox_pending(pending[1]),
    .port(rp));
  dpram_properties #(.ADDR_W(AW)) u_dpram_properties (.ref_clk(ref_clk), .rst(rst), .addr(lp.addr),
    .byte_lane_enable_n(lp.byte_lane_enable_n), .rd_wr(lp.rd_wr), .chip_select_low(lp.chip_select_low),
    .chip_select_high(lp.chip_select_high), .out_enable_n(lp.out_enable_n), .dq_host_oe_n(lp.dq_host_oe_n),
    .dq_from_dev(lp.dq_from_dev), .dq_dev_oe_n(lp.dq_dev_oe_n), .mailbox_flag_n(lp.mailbox_flag_n));

  task automatic close_out();
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk_data(input logic [35:0] g, input logic [35:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t data got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_flags(input logic [3:0] g, input logic [3:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t flags got %h exp %h", $time, g, e);
    end
  endtask

  // one request; waits bounded, a stuck handshake ends the run
  task automatic op(input row_t r);
    int n;
    n = 0;
    @(posedge ref_clk);
    req_valid[r.s] <= 1'h1;
    req_write[r.s] <= r.w;
    req_addr[r.s] <= r.a;
    req_lanes[r.s] <= r.ln;
    req_wdata[r.s] <= r.d;
    do begin
      @(negedge ref_clk);
      n++;
    end while (req_ready[r.s] !== 1'h1 && n < 20);
    @(posedge ref_clk);
    req_valid[r.s] <= 1'h0;
    while (!r.w && rsp_valid[r.s] !== 1'h1 && n < 30) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 20) begin
      mismatches++;
      close_out();
    end
    if (!r.w) chk_data(rsp_rdata[r.s], r.d);
  endtask

  // flag sync lags by a few clocks, so wait on both views
  task automatic wait_flags(input logic [1:0] e);
    int n;
    n = 0;
    while ((flag_n !== e || pending !== ~e) && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk_flags({flag_n, pending}, {e, ~e});
    if (n >= 20) begin
      mismatches++;
      close_out();
    end
  endtask

  initial begin
    req_valid = 2'h0;
    req_write = 2'h0;
    for (int s = 0; s < 2; s++) begin
      req_addr[s] = '0;
      req_lanes[s] = 4'h0;
      req_wdata[s] = 36'h000000000;
    end
    rows = '{'{0, 1'h1, 15'h0010, 4'hF, 36'h123456789}, '{1, 1'h0, 15'h0010, 4'hF, 36'h123456789},
             '{0, 1'h1, 15'h0010, 4'h2, 36'hFFFFFFFFF}, '{1, 1'h0, 15'h0010, 4'hF, 36'h12347FF89},
             '{1, 1'h0, 15'h0010, 4'h1, 36'h000000189}, '{0, 1'h1, 15'h0010, 4'h0, 36'h000000000},
             '{0, 1'h0, 15'h0010, 4'h8, 36'h120000000}, '{0, 1'h0, 15'h0010, 4'hF, 36'h12347FF89}};
    repeat (11) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_flags({flag_n, lp.dq_dev_oe_n, rp.dq_dev_oe_n}, 4'hF);
    @(posedge ref_clk);
    rst <= 1'h0;
    foreach (rows[i]) op(rows[i]);
    @(negedge ref_clk);
    chk_flags({flag_n, lp.dq_dev_oe_n, rp.dq_dev_oe_n}, 4'hF);
    for (int s = 0; s < 2; s++) begin
      op(row_t'{s, 1'h1, s ? 15'h7FFF : 15'h7FFE, 4'hF, 36'h0000000A5});
      wait_flags(s ? 2'h2 : 2'h1);
      op(row_t'{1 - s, 1'h0, s ? 15'h7FFF : 15'h7FFE, 4'hF, 36'h0000000A5});
      wait_flags(2'h3);
    end
    // reset in mid-run drops a pending message at once
    op(row_t'{0, 1'h1, 15'h7FFE, 4'hF, 36'h000000001});
    wait_flags(2'h1);
    @(posedge ref_clk);
    rst <= 1'h1;
    @(negedge ref_clk);
    chk_flags({flag_n, pending}, 4'hC);
    @(posedge ref_clk);
    rst <= 1'h0;
    // array contents survive reset, first request right after release
    op(row_t'{0, 1'h0, 15'h0010, 4'hF, 36'h12347FF89});
    chk_flags({flag_n, pending}, 4'hC);
    close_out();
  end
endmodule
`default_nettype wire
